// File: sps_defines.svh
/*
 * Offsets, reset values, timing counts and response codes of the servo pulse/status block.
 * Assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH
`define SPS_OFF_GEAR 8'h00
`define SPS_OFF_POS 8'h04
`define SPS_OFF_WIN 8'h08
`define SPS_OFF_SPD 8'h0c
`define SPS_OFF_SPW 8'h10
`define SPS_OFF_RAMP 8'h14
`define SPS_OFF_SCV 8'h18
`define SPS_OFF_CPOS 8'h20
`define SPS_OFF_APOS 8'h24
`define SPS_OFF_STAT 8'h28
`define SPS_NUM_CFG 7
`define SPS_RST_GEAR 32'h0001_0001
`define SPS_RST_POS 32'h0000_0000
`define SPS_RST_WIN 32'h03e8_0032
`define SPS_RST_SPD 32'h0000_0032
`define SPS_RST_SPW 32'h0000_0014
`define SPS_RST_RAMP 32'h0000_0000
`define SPS_RST_SCV 32'h0000_0000
`define SPS_CNT_PER_CYC 12000
`define SPS_CLK_NS 10
`define SPS_TUNIT_NS 10000000
`define SPS_TUNIT_CYC (`SPS_TUNIT_NS / `SPS_CLK_NS)
`define SPS_RESP_OKAY 2'b00
`define SPS_RESP_SLVERR 2'b10
`endif

// File: sps_pkg.sv
/*
 * Types of the servo pulse/status block.
 * Assumes sps_defines.svh for all numeric constants.
 */
package sps_pkg;
    typedef enum logic [7:0] {
        SPS_PT_PP = 8'h00,
        SPS_PT_QUAD = 8'h01,
        SPS_PT_PD = 8'h02,
        SPS_PT_PP_REV = 8'h10,
        SPS_PT_QUAD_REV = 8'h11,
        SPS_PT_PD_REV = 8'h12
    } sps_ptype_t;
    typedef struct packed {
        logic pos_match;
        logic motor_stopped;
        logic speed_match;
        logic at_marker;
    } sps_flags_t;
endpackage

// File: sps_servo_pulse_status.sv
/*
 * Command pulse decoder, feedback pulse output at the fixed 1:1 reset gear ratio, marker zero, coincidence flags,
 * torque clamp, speed ramps and analog reference polarity, behind an AXI4-Lite slave.
 * Assumes all inputs synchronous to aclk except cmd_pulse_a/b, and one feedback step per cycle.
 */
`timescale 1ns/1ps
`include "sps_defines.svh"
// How it works
// [R01] Output pulses scale feedback by den over num
// [R02] Internal resolution 12000 counts per resolver cycle
// [R03] Gear ratio adopted only at power-up; the copy always takes the 1:1 reset value
// [R04] Marker shift moves electrical zero, 0..11999
// [R05] One zero state per resolver cycle
// [R06] Zero pulse and stop marker use shifted zero
// [R07] Position coincidence inside position window
// [R08] Motor stopped while speed below limit
// [R09] Nonzero target: coincidence at target speed
// [R10] Zero target: coincidence at commanded speed
// [R11] Speed coincident within speed window
// [R12] Torque clamped to cap while limit applied
// [R13] Linear accel over accel time to rated
// [R14] Linear decel over decel time from rated
// [R15] Nonzero S time overrides linear ramps
// [R16] Set-zero or startup action per zero mode
// [R17] Reference polarity bits invert each reference
// [R18] Code 00: A increments, B decrements
// [R19] Code 01: quadrature by four, A leads up
// [R20] Code 02: A steps, B low increments
// [R21] Code 12: A steps, B high increments
// [R22] Code 10: B increments, A decrements
// [R23] Code 11: quadrature by four, B leads up
// [R24] Command inputs synchronised, then edge detected
module sps_servo_pulse_status #(
    parameter int RES_CYCLES = 1,
    parameter int RATED_RPM = 3000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmd_pulse_a,
    input wire logic cmd_pulse_b,
    input wire logic fb_inc,
    input wire logic fb_dec,
    input wire logic set_zero,
    input wire logic signed [15:0] act_speed,
    input wire logic signed [15:0] cmd_speed,
    input wire logic signed [15:0] torque_in,
    input wire logic torque_limit_en,
    input wire logic signed [15:0] analog_ref_a,
    input wire logic signed [15:0] analog_ref_b,
    output logic out_pulse_a,
    output logic out_pulse_b,
    output logic zero_pulse_out,
    output logic at_marker,
    output logic pos_match,
    output logic motor_stopped,
    output logic speed_match,
    output logic signed [15:0] torque_out,
    output logic signed [15:0] ref_a_out,
    output logic signed [15:0] ref_b_out,
    output logic signed [15:0] speed_ramp
);
    localparam int REV = `SPS_CNT_PER_CYC * RES_CYCLES; // [R02]
    localparam logic [31:0] TUNIT = 32'(`SPS_TUNIT_CYC);

    if (RES_CYCLES < 1 || RES_CYCLES > 16 || RATED_RPM < 1 || RATED_RPM > 32767) begin : g_bad
        $error("sps: RES_CYCLES or RATED_RPM out of range");
    end

    function automatic logic [16:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    endfunction

    logic [31:0] cfg_r [0:`SPS_NUM_CFG-1];
    logic [14:0] num_act_r, den_act_r;
    logic pup_r;
    logic signed [31:0] cmd_pos_r, act_pos_r;
    logic [13:0] elec_r;
    logic [17:0] rot_r;
    logic signed [23:0] res_r;
    logic [1:0] q_r;
    logic signed [15:0] tgt_r;
    logic [32:0] racc_r;
    logic [15:0] sdelta_r;
    logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
    logic wr_go, rd_go, wr_hit, rd_hit;
    logic [31:0] rd_val;

    wire [14:0] marker = cfg_r[1][13:0] < 14'(`SPS_CNT_PER_CYC) ? {1'b0, cfg_r[1][13:0]} : 15'h0;
    wire [1:0] zmode = cfg_r[1][17:16];
    wire [1:0] refpol = cfg_r[1][21:20];
    wire [14:0] pos_win = cfg_r[2][14:0];
    wire [9:0] tq_cap = cfg_r[2][25:16];
    wire [11:0] stop_lim = cfg_r[3][11:0];
    wire [11:0] sm_tgt = cfg_r[3][27:16];
    wire [11:0] sm_win = cfg_r[4][11:0];
    wire [7:0] ptype = cfg_r[4][23:16];
    wire [11:0] t_acc = cfg_r[5][11:0];
    wire [11:0] t_dec = cfg_r[5][27:16];
    wire [11:0] t_scv = cfg_r[6][11:0];

    // AXI4-Lite slave: both write channels taken together, one answer outstanding
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && !s_axi_rvalid;
    assign wr_hit = s_axi_awaddr[7:2] < 6'(`SPS_NUM_CFG) && s_axi_awaddr[1:0] == 2'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPS_RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= wr_go && !s_axi_awready;
            s_axi_wready <= wr_go && !s_axi_awready;
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r[0] <= `SPS_RST_GEAR;
            cfg_r[1] <= `SPS_RST_POS;
            cfg_r[2] <= `SPS_RST_WIN;
            cfg_r[3] <= `SPS_RST_SPD;
            cfg_r[4] <= `SPS_RST_SPW;
            cfg_r[5] <= `SPS_RST_RAMP;
            cfg_r[6] <= `SPS_RST_SCV;
        end else if (ce && s_axi_awready && wr_hit) begin
            for (int i = 0; i < 4; i++) begin
                if (s_axi_wstrb[i]) begin
                    cfg_r[s_axi_awaddr[4:2]][i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
                end
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0;
        case (s_axi_araddr)
            `SPS_OFF_GEAR, `SPS_OFF_POS, `SPS_OFF_WIN, `SPS_OFF_SPD, `SPS_OFF_SPW,
            `SPS_OFF_RAMP, `SPS_OFF_SCV: rd_val = cfg_r[s_axi_araddr[4:2]];
            `SPS_OFF_CPOS: rd_val = cmd_pos_r;
            `SPS_OFF_APOS: rd_val = act_pos_r;
            `SPS_OFF_STAT: rd_val = {8'h0, pos_match, motor_stopped, speed_match, at_marker,
                                     4'h0, speed_ramp};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SPS_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= rd_go && !s_axi_arready;
            if (rd_go && !s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Gear ratio is copied once after reset, from the 1:1 reset value; later writes are never adopted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pup_r <= 1'b1;
            num_act_r <= 15'h1;
            den_act_r <= 15'h1;
        end else if (ce && pup_r) begin
            pup_r <= 1'b0;
            num_act_r <= cfg_r[0][14:0] == 15'h0 ? 15'h1 : cfg_r[0][14:0]; // [R03]
            den_act_r <= cfg_r[0][30:16] == 15'h0 ? 15'h1 : cfg_r[0][30:16]; // [R03]
        end
    end

    // Command pulse decoder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {a_s1, a_s2, a_s3, b_s1, b_s2, b_s3} <= 6'h0;
        end else if (ce) begin
            {a_s1, a_s2, a_s3} <= {cmd_pulse_a, a_s1, a_s2}; // [R24]
            {b_s1, b_s2, b_s3} <= {cmd_pulse_b, b_s1, b_s2}; // [R24]
        end
    end

    wire a_edge = a_s2 ^ a_s3;
    wire b_edge = b_s2 ^ b_s3;
    wire a_rise = a_s2 && !a_s3;
    wire b_rise = b_s2 && !b_s3;
    // A-leads-B direction; a simultaneous edge on both lines is a lost step
    wire q_up = a_edge ? (a_s2 != b_s2) : (b_s2 == a_s2);
    wire q_ok = a_edge ^ b_edge;
    logic cmd_up, cmd_dn;

    always_comb begin
        cmd_up = 1'b0;
        cmd_dn = 1'b0;
        case (ptype)
            sps_pkg::SPS_PT_PP: begin
                cmd_up = a_rise && !b_rise; // [R18]
                cmd_dn = b_rise && !a_rise; // [R18]
            end
            sps_pkg::SPS_PT_QUAD: begin
                cmd_up = q_ok && q_up; // [R19]
                cmd_dn = q_ok && !q_up; // [R19]
            end
            sps_pkg::SPS_PT_PD: begin
                cmd_up = a_rise && !b_s2; // [R20]
                cmd_dn = a_rise && b_s2; // [R20]
            end
            sps_pkg::SPS_PT_PD_REV: begin
                cmd_up = a_rise && b_s2; // [R21]
                cmd_dn = a_rise && !b_s2; // [R21]
            end
            sps_pkg::SPS_PT_PP_REV: begin
                cmd_up = b_rise && !a_rise; // [R22]
                cmd_dn = a_rise && !b_rise; // [R22]
            end
            sps_pkg::SPS_PT_QUAD_REV: begin
                cmd_up = q_ok && !q_up; // [R23]
                cmd_dn = q_ok && q_up; // [R23]
            end
            default: begin
                cmd_up = 1'b0;
                cmd_dn = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_pos_r <= 32'sh0;
        end else if (ce) begin
            cmd_pos_r <= cmd_pos_r + 32'(cmd_up) - 32'(cmd_dn);
        end
    end

    // Feedback position, electrical and rotation counters, absolute zero
    wire fb_up = fb_inc && !fb_dec;
    wire fb_dn = fb_dec && !fb_inc;
    logic [13:0] elec_nxt;

    always_comb begin
        elec_nxt = elec_r;
        if (fb_up) begin
            elec_nxt = elec_r == 14'(`SPS_CNT_PER_CYC - 1) ? 14'h0 : elec_r + 14'h1; // [R05]
        end else if (fb_dn) begin
            elec_nxt = elec_r == 14'h0 ? 14'(`SPS_CNT_PER_CYC - 1) : elec_r - 14'h1; // [R05]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            elec_r <= 14'h0;
            rot_r <= 18'h0;
            act_pos_r <= 32'sh0;
            zero_pulse_out <= 1'b0;
            at_marker <= 1'b0;
        end else if (ce) begin
            elec_r <= elec_nxt;
            if (fb_up) begin
                rot_r <= rot_r == 18'(REV - 1) ? 18'h0 : rot_r + 18'h1;
            end else if (fb_dn) begin
                rot_r <= rot_r == 18'h0 ? 18'(REV - 1) : rot_r - 18'h1;
            end
            // Zero action acts on the position as it stood before this cycle's step
            if ((set_zero || pup_r) && zmode == 2'd0) begin
                act_pos_r <= 32'sh0; // [R16]
            end else if ((set_zero || pup_r) && zmode == 2'd1) begin
                act_pos_r <= 32'(rot_r) - 32'(marker); // [R16]
            end else begin
                act_pos_r <= act_pos_r + 32'(fb_up) - 32'(fb_dn);
            end
            zero_pulse_out <= (fb_up || fb_dn) && elec_nxt == 14'(marker); // [R04] [R06]
            at_marker <= elec_nxt == 14'(marker); // [R06]
        end
    end

    // Scaled output pulses; residue backlog drains one output step per cycle
    wire out_up = res_r >= $signed({9'h0, num_act_r});
    wire out_dn = res_r <= -$signed({9'h0, num_act_r});
    logic [1:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (out_up) begin
            q_nxt = q_r + 2'd1;
        end else if (out_dn) begin
            q_nxt = q_r - 2'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_r <= 24'sh0;
            q_r <= 2'd0;
            out_pulse_a <= 1'b0;
            out_pulse_b <= 1'b0;
        end else if (ce) begin
            res_r <= res_r + (fb_up ? $signed({9'h0, den_act_r}) : 24'sh0)
                - (fb_dn ? $signed({9'h0, den_act_r}) : 24'sh0)
                - (out_up ? $signed({9'h0, num_act_r}) : 24'sh0)
                + (out_dn ? $signed({9'h0, num_act_r}) : 24'sh0); // [R01]
            q_r <= q_nxt;
            out_pulse_a <= q_nxt[1] ^ q_nxt[0]; // [R01]
            out_pulse_b <= q_nxt[1];
        end
    end

    // Comparators, torque clamp, reference polarity
    wire signed [32:0] perr = 33'(cmd_pos_r) - 33'(act_pos_r);
    wire [32:0] perr_abs = perr[32] ? 33'(-perr) : perr;
    wire [16:0] act_abs = abs16(act_speed);
    wire [16:0] cmp_spd = sm_tgt != 12'h0 ? {5'h0, sm_tgt} : abs16(cmd_speed); // [R09] [R10]
    wire [16:0] sdiff = act_abs >= cmp_spd ? act_abs - cmp_spd : cmp_spd - act_abs;
    wire signed [16:0] cap_s = $signed({7'h0, tq_cap});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_match <= 1'b0;
            motor_stopped <= 1'b1;
            speed_match <= 1'b0;
            torque_out <= 16'sh0;
            ref_a_out <= 16'sh0;
            ref_b_out <= 16'sh0;
        end else if (ce) begin
            pos_match <= perr_abs <= 33'(pos_win); // [R07]
            motor_stopped <= act_abs < 17'(stop_lim); // [R08]
            speed_match <= sdiff <= 17'(sm_win); // [R11]
            if (torque_limit_en && 17'(torque_in) > cap_s) begin
                torque_out <= 16'(cap_s); // [R12]
            end else if (torque_limit_en && 17'(torque_in) < -cap_s) begin
                torque_out <= 16'(-cap_s); // [R12]
            end else begin
                torque_out <= torque_in;
            end
            // Negating -32768 saturates rather than wrapping
            ref_a_out <= refpol[0] ? (analog_ref_a == 16'sh8000 ? 16'sh7fff : -analog_ref_a)
                : analog_ref_a; // [R17]
            ref_b_out <= refpol[1] ? (analog_ref_b == 16'sh8000 ? 16'sh7fff : -analog_ref_b)
                : analog_ref_b; // [R17]
        end
    end

    // Speed ramp: rate accumulator advances one r/min when the time budget is spent.
    // The S profile is a constant-rate sweep over the whole S time, not true jerk shaping.
    wire accel = abs16(tgt_r) > abs16(speed_ramp);
    wire [11:0] t_sel = t_scv != 12'h0 ? t_scv : (accel ? t_acc : t_dec); // [R15]
    wire [32:0] thr = {1'b0, 32'(t_sel) * TUNIT};
    wire [32:0] rate = t_scv != 12'h0 ? {17'h0, sdelta_r} : 33'(RATED_RPM); // [R13] [R14]
    wire [32:0] racc_sum = racc_r + rate;
    wire [16:0] step_gap = abs16(16'(cmd_speed - speed_ramp));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tgt_r <= 16'sh0;
            sdelta_r <= 16'h0;
            racc_r <= 33'h0;
            speed_ramp <= 16'sh0;
        end else if (ce) begin
            tgt_r <= cmd_speed;
            if (cmd_speed != tgt_r) begin
                sdelta_r <= step_gap[16] ? 16'hffff : step_gap[15:0]; // [R15]
                racc_r <= 33'h0;
            end else if (speed_ramp == tgt_r) begin
                racc_r <= 33'h0;
            end else if (t_sel == 12'h0) begin
                speed_ramp <= tgt_r;
            end else if (racc_sum >= thr) begin
                racc_r <= racc_sum - thr;
                speed_ramp <= speed_ramp + (speed_ramp < tgt_r ? 16'sh1 : -16'sh1); // [R13] [R14]
            end else begin
                racc_r <= racc_sum;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_gear_hold;
        !pup_r |=> $stable(num_act_r) && $stable(den_act_r);
    endproperty
    a_gear_hold: assert property (p_gear_hold) else $error("gear changed after power-up"); // [R03]
    property p_zero_at_marker;
        zero_pulse_out |-> at_marker && elec_r == 14'(marker);
    endproperty
    a_zero_at_marker: assert property (p_zero_at_marker) else $error("zero pulse off marker"); // [R06]
    property p_pos_match;
        ce && perr_abs <= 33'(pos_win) |=> pos_match;
    endproperty
    a_pos_match: assert property (p_pos_match) else $error("position match missing"); // [R07]
    property p_stopped;
        ce && act_abs >= 17'(stop_lim) |=> !motor_stopped;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped flag above limit"); // [R08]
    property p_torque;
        ce && torque_limit_en |=> torque_out <= $past(cap_s) && torque_out >= -$past(cap_s);
    endproperty
    a_torque: assert property (p_torque) else $error("torque exceeds cap"); // [R12]
    property p_ramp_step;
        ce && t_sel != 12'h0 && cmd_speed == tgt_r |=>
            speed_ramp - $past(speed_ramp) <= 16'sh1 && $past(speed_ramp) - speed_ramp <= 16'sh1;
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp jumped"); // [R13]
    property p_pp_count;
        ce && ptype == 8'h00 && a_rise && !b_rise ##1 1'b1 |-> cmd_pos_r == $past(cmd_pos_r) + 1;
    endproperty
    a_pp_count: assert property (p_pp_count) else $error("pulse not counted"); // [R18]
    property p_ref_pol;
        ce && refpol[0] && analog_ref_a != 16'sh8000 |=> ref_a_out == -$past(analog_ref_a);
    endproperty
    a_ref_pol: assert property (p_ref_pol) else $error("reference not inverted"); // [R17]
    property p_out_quad;
        !(out_pulse_a != $past(out_pulse_a) && out_pulse_b != $past(out_pulse_b));
    endproperty
    a_out_quad: assert property (p_out_quad) else $error("both output lines moved"); // [R01]
    c_quad_up: cover property (ce && ptype == 8'h01 && cmd_up);
    c_zero: cover property (zero_pulse_out);
    c_ramp: cover property (speed_ramp != 16'sh0 && speed_ramp != tgt_r);
endmodule

// File: sps_ctrl_model.sv
/*
 * Behavioural motion controller driving the two command pulse lines.
 * Assumes the bench calls step() and that aclk is the block's clock.
 */
`timescale 1ns/1ps
module sps_ctrl_model (
    input wire logic aclk,
    output logic cmd_pulse_a,
    output logic cmd_pulse_b
);
    initial begin
        cmd_pulse_a = 1'b0;
        cmd_pulse_b = 1'b0;
    end
    // Gap of at least 2 keeps each level past the receiver's synchroniser
    task automatic drive(input logic a, input logic b, input int gap);
        @(posedge aclk);
        cmd_pulse_a <= a;
        cmd_pulse_b <= b;
        repeat (gap) @(posedge aclk);
    endtask
    task automatic step(input logic [7:0] code, input logic up, input int gap);
        logic q;
        q = (code == 8'h01) ? up : !up;
        case (code)
            8'h00: drive(up, !up, gap);
            8'h10: drive(!up, up, gap);
            8'h02: begin
                drive(1'b0, !up, gap);
                drive(1'b1, !up, gap);
                drive(1'b0, !up, gap);
            end
            8'h12: begin
                drive(1'b0, up, gap);
                drive(1'b1, up, gap);
                drive(1'b0, up, gap);
            end
            default: begin
                drive(q, !q, gap);
                drive(1'b1, 1'b1, gap);
                drive(!q, q, gap);
            end
        endcase
        drive(1'b0, 1'b0, gap);
    endtask
endmodule

// File: sps_servo_pulse_status_tb.sv
/*
 * Self-checking bench: AXI4-Lite register tasks, pulse decode, flags and datapath checks.
 * Assumes sps_ctrl_model as the controller and a 100 MHz clock.
 */
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_servo_pulse_status_tb;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cmd_pulse_a, cmd_pulse_b, fb_inc = 1'b0, fb_dec = 1'b0, set_zero = 1'b0;
    logic torque_limit_en = 1'b0;
    logic signed [15:0] act_speed = 16'sh0, cmd_speed = 16'sh0, torque_in = 16'sh0;
    logic signed [15:0] analog_ref_a = 16'sh0, analog_ref_b = 16'sh0;
    logic signed [15:0] torque_out, ref_a_out, ref_b_out, speed_ramp;
    logic out_pulse_a, out_pulse_b, zero_pulse_out, at_marker;
    logic pos_match, motor_stopped, speed_match;
    int mismatches = 0, compares = 0, cyc = 0, e = 0, i, j;
    logic [7:0] offs [7] = '{`SPS_OFF_GEAR, `SPS_OFF_POS, `SPS_OFF_WIN, `SPS_OFF_SPD,
        `SPS_OFF_SPW, `SPS_OFF_RAMP, `SPS_OFF_SCV};
    logic [31:0] rsts [7] = '{`SPS_RST_GEAR, `SPS_RST_POS, `SPS_RST_WIN, `SPS_RST_SPD,
        `SPS_RST_SPW, `SPS_RST_RAMP, `SPS_RST_SCV};
    logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h12};
    int sp_t [6] = '{0, 0, 0, 0, 500, 500};
    int sp_a [6] = '{49, 50, 980, 979, 520, 521};
    logic [1:0] sp_e [6] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b10, 2'b00};
    int tq_i [4] = '{1500, -1500, 500, 1500};
    int tq_e [4] = '{1000, -1000, 500, 1500};
    logic [1:0] quad [4] = '{2'b00, 2'b10, 2'b11, 2'b01};

    sps_servo_pulse_status dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cmd_pulse_a, .cmd_pulse_b, .fb_inc, .fb_dec, .set_zero, .act_speed, .cmd_speed,
        .torque_in, .torque_limit_en, .analog_ref_a, .analog_ref_b, .out_pulse_a,
        .out_pulse_b, .zero_pulse_out, .at_marker, .pos_match, .motor_stopped,
        .speed_match, .torque_out, .ref_a_out, .ref_b_out, .speed_ramp);
    sps_ctrl_model model (.aclk(aclk), .cmd_pulse_a(cmd_pulse_a), .cmd_pulse_b(cmd_pulse_b));

    always #5 aclk = ~aclk;

    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // Registered flags need a few edges before they are looked at
    task automatic st();
        repeat (4) @(posedge aclk);
        #1;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            print_verdict();
        end
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 7; i++) rd(offs[i], rsts[i], `SPS_RESP_OKAY);
        rd(`SPS_OFF_STAT, 32'h00f0_0000, `SPS_RESP_OKAY);
        rd(8'h1c, 32'h0, `SPS_RESP_SLVERR);
        wr(`SPS_OFF_CPOS, 32'h1, `SPS_RESP_SLVERR);
        // Three steps up, one down per code; gap grows to vary controller speed
        for (i = 0; i < 6; i++) begin
            wr(`SPS_OFF_SPW, {8'h0, codes[i], 16'h0014}, `SPS_RESP_OKAY);
            for (j = 0; j < 4; j++) model.step(codes[i], j != 3, 2 + i);
            e += (codes[i][3:0] == 4'h1) ? 8 : 2;
            st();
            rd(`SPS_OFF_CPOS, e, `SPS_RESP_OKAY);
        end
        for (j = 0; j < 2; j++) begin
            wr(`SPS_OFF_WIN, {16'h03e8, 16'(e - 1 + j)}, `SPS_RESP_OKAY);
            st();
            chk({31'h0, pos_match}, j);
        end
        @(posedge aclk);
        cmd_speed <= 16'sd1000;
        for (i = 0; i < 6; i++) begin
            wr(`SPS_OFF_SPD, {4'h0, 12'(sp_t[i]), 16'd50}, `SPS_RESP_OKAY);
            act_speed <= 16'(sp_a[i]);
            st();
            chk({30'h0, speed_match, motor_stopped}, {30'h0, sp_e[i]});
        end
        chk({16'h0, speed_ramp}, 32'd1000);
        // One r/min per ~334 cycles at rated 3000 over one 10 ms unit
        wr(`SPS_OFF_RAMP, 32'h0001_0001, `SPS_RESP_OKAY);
        for (j = 0; j < 2; j++) begin
            cmd_speed <= 16'(1001 - j);
            repeat (200) @(posedge aclk);
            chk({16'h0, speed_ramp}, 32'(1000 + j));
            repeat (200) @(posedge aclk);
            chk({16'h0, speed_ramp}, 32'(1001 - j));
        end
        wr(`SPS_OFF_SCV, 32'h1, `SPS_RESP_OKAY);
        cmd_speed <= 16'sd1001;
        repeat (400) @(posedge aclk);
        chk({16'h0, speed_ramp}, 32'd1000);
        for (i = 0; i < 4; i++) begin
            @(posedge aclk);
            torque_in <= 16'(tq_i[i]);
            torque_limit_en <= (i < 3);
            st();
            chk({16'h0, torque_out}, {16'h0, 16'(tq_e[i])});
        end
        for (i = 0; i < 4; i++) begin
            wr(`SPS_OFF_POS, {10'h0, 2'(i), 20'h0}, `SPS_RESP_OKAY);
            analog_ref_a <= 16'sd100;
            analog_ref_b <= -16'sd200;
            st();
            chk({ref_a_out, ref_b_out}, {i[0] ? -16'sd100 : 16'sd100,
                i[1] ? 16'sd200 : -16'sd200});
        end
        wr(`SPS_OFF_POS, 32'h3, `SPS_RESP_OKAY);
        for (i = 1; i < 6; i++) begin
            @(posedge aclk);
            fb_inc <= 1'b1;
            @(posedge aclk);
            fb_inc <= 1'b0;
            #1;
            chk({31'h0, zero_pulse_out}, (i == 3));
            st();
            chk({30'h0, out_pulse_a, out_pulse_b}, {30'h0, quad[i % 4]});
            chk({31'h0, at_marker}, (i == 3));
        end
        rd(`SPS_OFF_APOS, 32'd5, `SPS_RESP_OKAY);
        // Mode 1: rotation 5 less marker 3; mode 2 keeps that
        for (i = 0; i < 3; i++) begin
            wr(`SPS_OFF_POS, {14'h0, 2'(i), 16'h3}, `SPS_RESP_OKAY);
            set_zero <= 1'b1;
            @(posedge aclk);
            set_zero <= 1'b0;
            rd(`SPS_OFF_APOS, (i == 0) ? 32'd0 : 32'd2, `SPS_RESP_OKAY);
        end
        print_verdict();
    end
endmodule
